//--- pssc_cfg.svh
// Constants for the position switch-point compare block
`ifndef PSSC_CFG_SVH
`define PSSC_CFG_SVH

`define PSSC_POS_W 32
`define PSSC_PAR_W 8

// Parameter indices and subindices
`define PSSC_IDX_SP 8'h3c
`define PSSC_IDX_SSC 8'h41
`define PSSC_IDX_WRAP 8'h64
`define PSSC_SUB_0 8'h00
`define PSSC_SUB_1 8'h01
`define PSSC_SUB_2 8'h02
`define PSSC_SUB_3 8'h03

// Encodings of the configuration bytes
`define PSSC_MODE_OFF 8'h00
`define PSSC_MODE_SINGLE 8'h01
`define PSSC_MODE_WINDOW 8'h02
`define PSSC_POL_HIGH 8'h00
`define PSSC_POL_LOW 8'h01

// Reset values
`define PSSC_RST_WRAP 32'h0000ffff
`define PSSC_RST_SP 32'h00000000
`define PSSC_RST_HYST 32'h00000000
`define PSSC_RST_MODE 8'h00
`define PSSC_RST_POL 8'h00

`endif

//--- pssc_pkg.sv
// Types shared by the position switch-point compare block
package pssc_pkg;
  typedef enum logic [1:0] {
    PSSC_SEC_OUT,
    PSSC_SEC_LOW_BAND,
    PSSC_SEC_WINDOW,
    PSSC_SEC_HIGH_BAND
  } pssc_sector_t;

  typedef enum logic [1:0] {
    PSSC_M_OFF,
    PSSC_M_SINGLE,
    PSSC_M_WINDOW
  } pssc_mode_t;
endpackage

//--- pssc_thr_if.sv
// Position and thresholds passed from the top to the sector classifier
`timescale 1ns/1ps
interface pssc_thr_if;
  logic [31:0] position;
  logic [31:0] band_lo;
  logic [31:0] sp_lo;
  logic [31:0] sp_hi;
  logic [31:0] band_hi;

  modport drive (
    output position,
    output band_lo,
    output sp_lo,
    output sp_hi,
    output band_hi
  );

  modport classify (
    input position,
    input band_lo,
    input sp_lo,
    input sp_hi,
    input band_hi
  );
endinterface

//--- pssc_pos_track.sv
// Position counter that wraps between zero and the wrap limit
`timescale 1ns/1ps
`include "pssc_cfg.svh"
module pssc_pos_track
  import pssc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic step_valid,
  input wire logic step_up,
  input wire logic [`PSSC_POS_W-1:0] wrap_limit,
  output logic [`PSSC_POS_W-1:0] position_ff,
  output logic sample_ff
);

  logic [`PSSC_POS_W-1:0] nxt_position;

  // Wrap in both directions
  always_comb begin
    nxt_position = position_ff;
    if (position_ff > wrap_limit) begin
      // Limit lowered under a live position; restart from zero
      nxt_position = '0;
    end else if (step_valid && step_up) begin
      if (position_ff >= wrap_limit) begin
        nxt_position = '0;
      end else begin
        nxt_position = position_ff + 32'h00000001;
      end
    end else if (step_valid) begin
      if (position_ff == '0) begin
        nxt_position = wrap_limit;
      end else begin
        nxt_position = position_ff - 32'h00000001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      position_ff <= '0;
    end else begin
      position_ff <= nxt_position;
    end
  end

  // New sample marker, one cycle after the step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_ff <= 1'b0;
    end else begin
      sample_ff <= step_valid;
    end
  end

endmodule

//--- pssc_sector.sv
// Sector classifier for the window compare
`timescale 1ns/1ps
module pssc_sector
  import pssc_pkg::*;
(
  pssc_thr_if.classify thr,
  output pssc_sector_t sector
);

  // Bands sit outside the window; band edges are already clamped
  always_comb begin
    if (thr.position >= thr.sp_lo && thr.position <= thr.sp_hi) begin
      sector = PSSC_SEC_WINDOW;
    end else if (thr.position >= thr.band_lo && thr.position < thr.sp_lo) begin
      sector = PSSC_SEC_LOW_BAND;
    end else if (thr.position > thr.sp_hi && thr.position <= thr.band_hi) begin
      sector = PSSC_SEC_HIGH_BAND;
    end else begin
      sector = PSSC_SEC_OUT;
    end
  end

endmodule

//--- pssc_top.sv
// Switch-point compare of the measured position, with wrap limit and hysteresis
`timescale 1ns/1ps
`include "pssc_cfg.svh"
module pssc_top
  import pssc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pos_step_valid,
  input wire logic pos_step_up,
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [`PSSC_PAR_W-1:0] param_index,
  input wire logic [`PSSC_PAR_W-1:0] param_sub,
  input wire logic [`PSSC_POS_W-1:0] param_wdata,
  output logic [`PSSC_POS_W-1:0] param_rdata,
  output logic param_ack,
  output logic param_err,
  output logic [`PSSC_POS_W-1:0] measured_position_channel,
  output logic [2:0] position_sector,
  output logic switching_output_one
);

  // Saturating subtract, floor at zero
  function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [31:0] b);
    sat_sub = (a > b) ? (a - b) : 32'h00000000;
  endfunction

  // Saturating add, ceiling at the wrap limit
  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b,
                                          input logic [31:0] lim);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s >= {1'b0, lim}) ? lim : s[31:0];
  endfunction

  // Clamp a switch point to the wrap limit
  function automatic logic [31:0] clamp_sp(input logic [31:0] sp, input logic [31:0] lim);
    clamp_sp = (sp >= lim) ? lim : sp;
  endfunction

  // Smaller of two switch points; the points may be written in either order
  function automatic logic [31:0] min_u(input logic [31:0] a, input logic [31:0] b);
    min_u = (a < b) ? a : b;
  endfunction

  // Larger of two switch points
  function automatic logic [31:0] max_u(input logic [31:0] a, input logic [31:0] b);
    max_u = (a < b) ? b : a;
  endfunction

  // Parameter address match; index and subindex must both agree
  function automatic logic addr_is(input logic [7:0] idx, input logic [7:0] sub, input logic [7:0] want_idx,
                                   input logic [7:0] want_sub);
    addr_is = (idx == want_idx) && (sub == want_sub);
  endfunction

  // Mode byte to mode type; unknown codes act as off
  function automatic pssc_mode_t decode_mode(input logic [7:0] m);
    case (m)
      `PSSC_MODE_SINGLE: decode_mode = PSSC_M_SINGLE;
      `PSSC_MODE_WINDOW: decode_mode = PSSC_M_WINDOW;
      default: decode_mode = PSSC_M_OFF;
    endcase
  endfunction

  // Sector to its 1..4 number
  function automatic logic [2:0] sector_num(input pssc_sector_t s);
    case (s)
      PSSC_SEC_OUT: sector_num = 3'h1;
      PSSC_SEC_LOW_BAND: sector_num = 3'h2;
      PSSC_SEC_WINDOW: sector_num = 3'h3;
      PSSC_SEC_HIGH_BAND: sector_num = 3'h4;
      default: sector_num = 3'h0;
    endcase
  endfunction

  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Stored parameters
  logic [31:0] wrap_ff;
  logic [31:0] sp_first_ff;
  logic [31:0] sp_second_ff;
  logic [31:0] hyst_ff;
  logic [7:0] mode_ff;
  logic [7:0] pol_ff;

  // Position and working thresholds
  logic [31:0] pos_now;
  logic pos_sample;
  logic [31:0] sp_first_eff;
  logic [31:0] sp_second_eff;
  logic [31:0] sp_lo;
  logic [31:0] sp_hi;

  // Compare state
  pssc_mode_t mode_now;
  pssc_sector_t sector_now;
  pssc_sector_t sector_ff;
  logic state_ff;
  logic nxt_state;

  // Parameter decode
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_value;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Address decode of the parameter port
  always_comb begin
    wr_hit = 1'b1;
    rd_value = 32'h00000000;
    if (addr_is(param_index, param_sub, `PSSC_IDX_SP, `PSSC_SUB_1)) begin
      rd_value = sp_first_ff;
    end else if (addr_is(param_index, param_sub, `PSSC_IDX_SP, `PSSC_SUB_2)) begin
      rd_value = sp_second_ff;
    end else if (addr_is(param_index, param_sub, `PSSC_IDX_SSC, `PSSC_SUB_1)) begin
      rd_value = {24'h000000, pol_ff};
    end else if (addr_is(param_index, param_sub, `PSSC_IDX_SSC, `PSSC_SUB_2)) begin
      rd_value = {24'h000000, mode_ff};
    end else if (addr_is(param_index, param_sub, `PSSC_IDX_SSC, `PSSC_SUB_3)) begin
      rd_value = hyst_ff;
    end else if (addr_is(param_index, param_sub, `PSSC_IDX_WRAP, `PSSC_SUB_0)) begin
      rd_value = wrap_ff;
    end else begin
      wr_hit = 1'b0;
    end
  end

  assign rd_hit = wr_hit;

  // Switch points: any value is stored, even above the wrap limit
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sp_first_ff <= `PSSC_RST_SP;
      sp_second_ff <= `PSSC_RST_SP;
    end else if (param_wr && param_index == `PSSC_IDX_SP) begin
      if (param_sub == `PSSC_SUB_1) begin
        sp_first_ff <= param_wdata;
      end else if (param_sub == `PSSC_SUB_2) begin
        sp_second_ff <= param_wdata;
      end
    end
  end

  // Output configuration: polarity, compare mode, shared hysteresis
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pol_ff <= `PSSC_RST_POL;
      mode_ff <= `PSSC_RST_MODE;
      hyst_ff <= `PSSC_RST_HYST;
    end else if (param_wr && param_index == `PSSC_IDX_SSC) begin
      if (param_sub == `PSSC_SUB_1) begin
        pol_ff <= param_wdata[7:0];
      end else if (param_sub == `PSSC_SUB_2) begin
        mode_ff <= param_wdata[7:0];
      end else if (param_sub == `PSSC_SUB_3) begin
        hyst_ff <= param_wdata;
      end
    end
  end

  // Wrap limit
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      wrap_ff <= `PSSC_RST_WRAP;
    end else if (param_wr && addr_is(param_index, param_sub, `PSSC_IDX_WRAP, `PSSC_SUB_0)) begin
      wrap_ff <= param_wdata;
    end
  end

  // Handshake: ack every access one cycle later, err for unmapped ones
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      param_ack <= 1'b0;
      param_err <= 1'b0;
    end else begin
      param_ack <= param_wr | param_rd;
      param_err <= (param_wr | param_rd) & ~wr_hit;
    end
  end

  // Read data holds until the next read, so a slow master can still pick it up
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      param_rdata <= 32'h00000000;
    end else if (param_rd) begin
      param_rdata <= rd_hit ? rd_value : 32'h00000000;
    end
  end

  // Position counter
  pssc_pos_track u_track (
    .core_clk(core_clk),
    .rst_n(rst_sync_ff),
    .step_valid(pos_step_valid),
    .step_up(pos_step_up),
    .wrap_limit(wrap_ff),
    .position_ff(pos_now),
    .sample_ff(pos_sample)
  );

  // Working thresholds; a point past the limit becomes the limit and so trips only when the position reaches the limit
  assign sp_first_eff = clamp_sp(sp_first_ff, wrap_ff);
  assign sp_second_eff = clamp_sp(sp_second_ff, wrap_ff);
  assign sp_lo = min_u(sp_first_eff, sp_second_eff);
  assign sp_hi = max_u(sp_first_eff, sp_second_eff);
  assign mode_now = decode_mode(mode_ff);

  pssc_thr_if thr ();

  // Band edges saturate at zero and at the wrap limit
  assign thr.position = pos_now;
  assign thr.sp_lo = sp_lo;
  assign thr.sp_hi = sp_hi;
  assign thr.band_lo = sat_sub(sp_lo, hyst_ff);
  assign thr.band_hi = sat_add(sp_hi, hyst_ff, wrap_ff);

  pssc_sector u_sector (
    .thr(thr),
    .sector(sector_now)
  );

  // Output state; in window mode from departing sector, arriving sector and present state
  always_comb begin
    nxt_state = state_ff;
    case (mode_now)
      PSSC_M_SINGLE: begin
        // Single point uses the first point, clamped, with a lower band floored at zero
        if (pos_now >= sp_first_eff) begin
          nxt_state = 1'b1;
        end else if (pos_now < sat_sub(sp_first_eff, hyst_ff)) begin
          nxt_state = 1'b0;
        end
      end
      PSSC_M_WINDOW: begin
        if (sector_now != sector_ff) begin
          case (sector_now)
            PSSC_SEC_WINDOW: nxt_state = 1'b0;
            PSSC_SEC_OUT: nxt_state = 1'b1;
            default: nxt_state = state_ff;
          endcase
        end
      end
      default: nxt_state = 1'b0;
    endcase
  end

  // Output state moves only when a fresh sample lands
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= 1'b0;
    end else if (pos_sample) begin
      state_ff <= nxt_state;
    end
  end

  // Sector memory kept in every mode, so a mode change starts from the real sector
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sector_ff <= PSSC_SEC_OUT;
    end else if (pos_sample) begin
      sector_ff <= sector_now;
    end
  end

  // Polarity applied last so the hysteresis memory is independent of it
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      switching_output_one <= 1'b0;
    end else if (pol_ff == `PSSC_POL_LOW) begin
      switching_output_one <= ~state_ff;
    end else begin
      switching_output_one <= state_ff;
    end
  end

  // Observed position, one cycle behind the internal copy
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      measured_position_channel <= 32'h00000000;
    end else begin
      measured_position_channel <= pos_now;
    end
  end

  // Sector number of the last evaluated sample
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      position_sector <= 3'h1;
    end else begin
      position_sector <= sector_num(sector_ff);
    end
  end

endmodule

//--- pssc_props.sv
// Port checker for the switch-point compare top
`timescale 1ns/1ps
module pssc_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pos_step_valid,
  input wire logic pos_step_up,
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [31:0] param_rdata,
  input wire logic param_ack,
  input wire logic param_err,
  input wire logic [31:0] measured_position_channel,
  input wire logic [2:0] position_sector,
  input wire logic switching_output_one
);
  // Recent steps and writes, the only causes of output motion
  logic [3:0] step_hist_ff;
  logic [3:0] wr_hist_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      step_hist_ff <= 4'h0;
      wr_hist_ff <= 4'h0;
    end else begin
      step_hist_ff <= {step_hist_ff[2:0], pos_step_valid};
      wr_hist_ff <= {wr_hist_ff[2:0], param_wr};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Step taken, then two edges until the position shows
  sequence s_step_up;
    pos_step_valid && pos_step_up ##2 1'b1;
  endsequence
  sequence s_step_dn;
    pos_step_valid && !pos_step_up ##2 1'b1;
  endsequence
  a_ack_on_req: assert property ((param_wr || param_rd) |=> param_ack)
    else $error("no ack after request");
  a_ack_has_cause: assert property (param_ack |-> $past(param_wr || param_rd))
    else $error("ack without request");
  a_err_with_ack: assert property (param_err |-> param_ack)
    else $error("err without ack");
  a_rdata_held: assert property (!param_rd |=> $stable(param_rdata))
    else $error("read data moved without read");
  a_up_step: assert property (s_step_up |-> measured_position_channel == $past(measured_position_channel) + 32'h1
    || measured_position_channel == 32'h0) else $error("bad upward step");
  a_dn_step: assert property (s_step_dn |-> measured_position_channel == $past(measured_position_channel) - 32'h1
    || $past(measured_position_channel) == 32'h0) else $error("bad downward step");
  a_sector_range: assert property (position_sector >= 3'h1 && position_sector <= 3'h4)
    else $error("sector out of range");
  a_sector_cause: assert property ($changed(position_sector) |-> step_hist_ff[2] || wr_hist_ff != 4'h0)
    else $error("sector moved without cause");
  a_out_cause: assert property ($changed(switching_output_one) |-> step_hist_ff[2] || wr_hist_ff != 4'h0)
    else $error("output moved without cause");
endmodule

bind pssc_top pssc_props i_pssc_props (.core_clk(core_clk), .resetn(resetn), .pos_step_valid(pos_step_valid),
  .pos_step_up(pos_step_up), .param_wr(param_wr), .param_rd(param_rd), .param_rdata(param_rdata),
  .param_ack(param_ack), .param_err(param_err), .measured_position_channel(measured_position_channel),
  .position_sector(position_sector), .switching_output_one(switching_output_one));

//--- pssc_master.sv
// Parameter master standing in for the link master
`timescale 1ns/1ps
module pssc_master (
  input wire logic core_clk,
  output logic param_wr,
  output logic param_rd,
  output logic [7:0] param_index,
  output logic [7:0] param_sub,
  output logic [31:0] param_wdata,
  input wire logic [31:0] param_rdata,
  input wire logic param_ack,
  input wire logic param_err
);
  initial begin
    param_wr = 1'b0;
    param_rd = 1'b0;
    param_index = 8'h00;
    param_sub = 8'h00;
    param_wdata = 32'h0;
  end
  // One-cycle request, answer looked at one cycle later
  task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] sub, input logic [31:0] data,
                        output logic [31:0] rd, output logic err, output logic ack);
    @(posedge core_clk);
    param_wr <= wr;
    param_rd <= !wr;
    param_index <= idx;
    param_sub <= sub;
    param_wdata <= data;
    @(posedge core_clk);
    param_wr <= 1'b0;
    param_rd <= 1'b0;
    // Released bus shows junk, not the last address
    param_index <= ~idx;
    param_sub <= ~sub;
    param_wdata <= ~data;
    #1;
    ack = param_ack;
    err = param_err;
    rd = param_rdata;
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the switch-point compare top
`timescale 1ns/1ps
`include "pssc_cfg.svh"
module tb_top;
  logic core_clk, resetn, pos_step_valid, pos_step_up, param_wr, param_rd, param_ack, param_err, sw_out, err, ack;
  logic [7:0] param_index, param_sub;
  logic [31:0] param_wdata, param_rdata, meas, pos_exp, wrap_exp, rd;
  logic [2:0] sector;
  int errors, n_tests, cyc;
  pssc_top i_pssc_top (.core_clk(core_clk), .resetn(resetn), .pos_step_valid(pos_step_valid),
    .pos_step_up(pos_step_up), .param_wr(param_wr), .param_rd(param_rd), .param_index(param_index),
    .param_sub(param_sub), .param_wdata(param_wdata), .param_rdata(param_rdata), .param_ack(param_ack),
    .param_err(param_err), .measured_position_channel(meas), .position_sector(sector),
    .switching_output_one(sw_out));
  pssc_master i_pssc_master (.core_clk(core_clk), .param_wr(param_wr), .param_rd(param_rd),
    .param_index(param_index), .param_sub(param_sub), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .param_ack(param_ack), .param_err(param_err));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc >= 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic par(input logic wr, input logic [7:0] idx, input logic [7:0] sub, input logic [31:0] d,
                     input logic e);
    i_pssc_master.access(wr, idx, sub, d, rd, err, ack);
    chk({30'h0, ack, err}, {30'h0, 1'b1, e});
    if (!wr) chk(rd, d);
  endtask
  // Step is taken one edge after launch; position shows one edge later, sector and output two, checked after three
  task automatic step(input logic up);
    @(posedge core_clk);
    pos_step_valid <= 1'b1;
    pos_step_up <= up;
    @(posedge core_clk);
    pos_step_valid <= 1'b0;
    if (up) pos_exp = (pos_exp == wrap_exp) ? 32'h0 : pos_exp + 32'h1;
    else pos_exp = (pos_exp == 32'h0) ? wrap_exp : pos_exp - 32'h1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(meas, pos_exp);
  endtask
  task automatic t_regs();
    par(1'b0, `PSSC_IDX_WRAP, `PSSC_SUB_0, `PSSC_RST_WRAP, 1'b0);
    par(1'b0, `PSSC_IDX_SSC, `PSSC_SUB_1, 32'h0, 1'b0);
    par(1'b0, `PSSC_IDX_SSC, `PSSC_SUB_2, 32'h0, 1'b0);
    par(1'b0, 8'h50, `PSSC_SUB_1, 32'h0, 1'b1);
    par(1'b1, `PSSC_IDX_WRAP, `PSSC_SUB_0, 32'h5, 1'b0);
    wrap_exp = 32'h5;
    par(1'b1, `PSSC_IDX_SP, `PSSC_SUB_1, 32'h9, 1'b0);
    par(1'b0, `PSSC_IDX_SP, `PSSC_SUB_1, 32'h9, 1'b0);
    $display("t_regs done");
  endtask
  task automatic t_wrap();
    for (int i = 0; i < 6; i++) step(1'b1);
    chk(meas, 32'h0);
    step(1'b0);
    chk(meas, 32'h5);
    step(1'b1);
    $display("t_wrap done");
  endtask
  task automatic t_single();
    par(1'b1, `PSSC_IDX_SSC, `PSSC_SUB_2, {24'h0, `PSSC_MODE_SINGLE}, 1'b0);
    for (int i = 0; i < 4; i++) step(1'b1);
    chk({31'h0, sw_out}, 32'h0);
    step(1'b1);
    chk({31'h0, sw_out}, 32'h1);
    par(1'b1, `PSSC_IDX_SP, `PSSC_SUB_1, 32'h3, 1'b0);
    par(1'b1, `PSSC_IDX_SSC, `PSSC_SUB_3, 32'h1, 1'b0);
    for (int i = 0; i < 3; i++) step(1'b0);
    chk({31'h0, sw_out}, 32'h1);
    step(1'b0);
    chk({31'h0, sw_out}, 32'h0);
    par(1'b1, `PSSC_IDX_SSC, `PSSC_SUB_1, {24'h0, `PSSC_POL_LOW}, 1'b0);
    step(1'b1);
    chk({31'h0, sw_out}, 32'h1);
    par(1'b1, `PSSC_IDX_SSC, `PSSC_SUB_1, {24'h0, `PSSC_POL_HIGH}, 1'b0);
    par(1'b1, `PSSC_IDX_SP, `PSSC_SUB_1, 32'h1, 1'b0);
    par(1'b1, `PSSC_IDX_SSC, `PSSC_SUB_3, 32'h3, 1'b0);
    step(1'b0);
    step(1'b0);
    chk({31'h0, sw_out}, 32'h1);
    step(1'b0);
    $display("t_single done");
  endtask
  // Window 8..12, bands 6..7 and 13..14; walk up to 15 and back to 5
  task automatic t_window();
    logic [2:0] s, prev;
    logic st, known;
    par(1'b1, `PSSC_IDX_WRAP, `PSSC_SUB_0, 32'h14, 1'b0);
    wrap_exp = 32'h14;
    par(1'b1, `PSSC_IDX_SP, `PSSC_SUB_1, 32'hc, 1'b0);
    par(1'b1, `PSSC_IDX_SP, `PSSC_SUB_2, 32'h8, 1'b0);
    par(1'b1, `PSSC_IDX_SSC, `PSSC_SUB_3, 32'h2, 1'b0);
    par(1'b1, `PSSC_IDX_SSC, `PSSC_SUB_2, {24'h0, `PSSC_MODE_WINDOW}, 1'b0);
    prev = 3'h1;
    known = 1'b0;
    st = 1'b0;
    for (int i = 0; i < 20; i++) begin
      step(i < 10);
      s = (pos_exp >= 8 && pos_exp <= 12) ? 3'h3 : (pos_exp >= 6 && pos_exp < 8) ? 3'h2 :
          (pos_exp > 12 && pos_exp <= 14) ? 3'h4 : 3'h1;
      if (s == 3'h3 && prev != 3'h3) begin
        st = 1'b0;
        known = 1'b1;
      end else if (s == 3'h1 && (prev == 3'h2 || prev == 3'h4)) begin
        st = 1'b1;
        known = 1'b1;
      end
      chk({29'h0, sector}, {29'h0, s});
      if (known) chk({31'h0, sw_out}, {31'h0, st});
      prev = s;
    end
    // Unknown mode code acts as off and forces the state low on the next sample
    par(1'b1, `PSSC_IDX_SSC, `PSSC_SUB_2, 32'h00000003, 1'b0);
    par(1'b0, `PSSC_IDX_SSC, `PSSC_SUB_2, 32'h00000003, 1'b0);
    step(1'b0);
    chk({31'h0, sw_out}, 32'h0);
    $display("t_window done");
  endtask
  initial begin
    errors = 0;
    n_tests = 0;
    cyc = 0;
    pos_exp = 32'h0;
    wrap_exp = `PSSC_RST_WRAP;
    resetn = 1'b0;
    pos_step_valid = 1'b0;
    pos_step_up = 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_wrap();
    t_single();
    t_window();
    print_verdict();
  end
endmodule
